// File: hdl/ofc_pkg.sv
// Constants, register map and types of the flag offset configuration block
package ofc_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int OFC_DEPTH = 1024;
    localparam int OFC_OFS_W = 10;
    localparam int OFC_CNT_W = 11;
    localparam int OFC_DATA_W = 36;
    localparam int OFC_ADDR_W = 8;
    localparam int OFC_IRQ_W = 4;
    localparam int OFC_SER_BITS = 2 * OFC_OFS_W;
    localparam int OFC_SER_CNT_W = 5;
    localparam logic [OFC_SER_CNT_W-1:0] OFC_SER_LAST = 5'h13;
    localparam logic [OFC_CNT_W:0] OFC_DEPTH_X = 12'h400;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [OFC_ADDR_W-1:0] OFC_ADDR_CTRL = 8'h00;
    localparam logic [OFC_ADDR_W-1:0] OFC_ADDR_EMPTY_OFS = 8'h04;
    localparam logic [OFC_ADDR_W-1:0] OFC_ADDR_FULL_OFS = 8'h08;
    localparam logic [OFC_ADDR_W-1:0] OFC_ADDR_SERIAL_IN = 8'h0C;
    localparam logic [OFC_ADDR_W-1:0] OFC_ADDR_FLAGS = 8'h10;
    localparam logic [OFC_ADDR_W-1:0] OFC_ADDR_IRQ_STAT = 8'h14;
    localparam logic [OFC_ADDR_W-1:0] OFC_ADDR_IRQ_MASK = 8'h18;
    localparam logic [OFC_ADDR_W-1:0] OFC_ADDR_COUNT = 8'h1C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int OFC_CTRL_SERIAL_BIT = 0;
    localparam int OFC_CTRL_IN_MR_BIT = 1;
    localparam int OFC_FLAG_AE_N_BIT = 0;
    localparam int OFC_FLAG_AF_N_BIT = 1;
    localparam int OFC_IRQ_AE = 0;
    localparam int OFC_IRQ_AF = 1;
    localparam int OFC_IRQ_MR_DONE = 2;
    localparam int OFC_IRQ_SER_DONE = 3;

    // ------------------------------------------------------------------
    // Default offsets and reset values
    // ------------------------------------------------------------------
    localparam logic [OFC_OFS_W-1:0] OFC_OFS_511 = 10'h1FF;
    localparam logic [OFC_OFS_W-1:0] OFC_OFS_255 = 10'h0FF;
    localparam logic [OFC_OFS_W-1:0] OFC_OFS_127 = 10'h07F;
    localparam logic [OFC_OFS_W-1:0] OFC_OFS_63 = 10'h03F;
    localparam logic [OFC_OFS_W-1:0] OFC_OFS_31 = 10'h01F;
    localparam logic [OFC_OFS_W-1:0] OFC_OFS_15 = 10'h00F;
    localparam logic [OFC_OFS_W-1:0] OFC_OFS_7 = 10'h007;
    localparam logic [OFC_OFS_W-1:0] OFC_OFS_3 = 10'h003;
    localparam logic [OFC_OFS_W-1:0] OFC_OFS_RST = 10'h07F;
    localparam logic [OFC_IRQ_W-1:0] OFC_IRQ_MASK_RST = 4'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OFC_ST_HOLD = 2'b00,
        OFC_ST_LOAD = 2'b01,
        OFC_ST_RUN = 2'b11
    } ofc_state_t;

endpackage : ofc_pkg

// File: hdl/ofc_ser_if.sv
// Interface between the control core and the serial offset loader
`timescale 1ns/100ps
interface ofc_ser_if;
    import ofc_pkg::*;
    logic clear;
    logic bit_valid;
    logic bit_val;
    logic word_valid;
    logic [OFC_OFS_W-1:0] empty_word;
    logic [OFC_OFS_W-1:0] full_word;

    modport core (
        output clear,
        output bit_valid,
        output bit_val,
        input word_valid,
        input empty_word,
        input full_word
    );
    modport loader (
        input clear,
        input bit_valid,
        input bit_val,
        output word_valid,
        output empty_word,
        output full_word
    );
endinterface : ofc_ser_if

// File: hdl/ofc_serial_loader.sv
// Serial offset loader: assembles empty then full offset, LSB first
`timescale 1ns/100ps
module ofc_serial_loader
    import ofc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    ofc_ser_if.loader ser
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [OFC_SER_BITS-1:0] shift;
        logic [OFC_SER_CNT_W-1:0] cnt;
        logic done;
    } ofc_ld_state_t;

    ofc_ld_state_t s_q;
    ofc_ld_state_t s_d;

    // Shift in from the top so the first bit ends at bit 0
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (ser.clear) begin
            s_d.cnt = '0;
        end else if (ser.bit_valid) begin
            s_d.shift = {ser.bit_val, s_q.shift[OFC_SER_BITS-1:1]};
            if (s_q.cnt == OFC_SER_LAST) begin
                s_d.cnt = '0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 5'h01;
            end
        end
    end

    // Register the state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ser.word_valid = s_q.done;
    assign ser.empty_word = s_q.shift[OFC_OFS_W-1:0];
    assign ser.full_word = s_q.shift[OFC_SER_BITS-1:OFC_OFS_W];

endmodule : ofc_serial_loader

// File: hdl/ofc_core.sv
// Flag offset selection, programming, read-back and threshold flags
//
// Summary of operation
// - In master reset the pins pick one default, 511 to 3, for both offsets.
// - Load-select high in master reset enables serial programming.
// - Load-select low in master reset enables parallel programming.
// - Either mode loads the default picked by load-select and both select pins.
// - Offsets read back on the parallel data output in either mode.
// - There is no serial read-back path at all.
// - Offsets may be reprogrammed any time after master reset ends.
// - The empty offset n is the threshold of the almost-empty flag.
// - The full offset m is the threshold of the almost-full flag.
// - The almost-empty flag goes high once the word count exceeds n.
// - The almost-empty flag goes low again when n words remain.
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module ofc_core
    import ofc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic master_reset_n_i,
    input wire logic offset_load_select_n_i,
    input wire logic default_offset_sel_bit0_i,
    input wire logic default_offset_sel_bit1_i,
    input wire logic [OFC_CNT_W-1:0] fifo_count_i,
    input wire logic offset_read_i,
    input wire logic [OFC_ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [31:0] rdata_o,
    output logic [OFC_DATA_W-1:0] parallel_data_out_o,
    output logic almost_empty_flag_n_o,
    output logic almost_full_flag_n_o,
    output logic serial_mode_o,
    output logic irq_o
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        logic mr_meta;
        logic mr_sync;
        logic ld_meta;
        logic ld_sync;
        logic [1:0] fs_meta;
        logic [1:0] fs_sync;
        ofc_state_t st;
        logic serial_mode;
        logic [OFC_OFS_W-1:0] empty_ofs;
        logic [OFC_OFS_W-1:0] full_ofs;
        logic ae_n;
        logic af_n;
        logic [OFC_IRQ_W-1:0] irq_stat;
        logic [OFC_IRQ_W-1:0] irq_mask;
        logic irq;
        logic [31:0] rdata;
        logic [OFC_DATA_W-1:0] pdo;
        logic rb_full;
    } ofc_core_state_t;

    // Reset image: master reset assumed active, parallel mode
    localparam ofc_core_state_t OFC_CORE_RST = '{
        mr_meta: 1'b0,
        mr_sync: 1'b0,
        ld_meta: 1'b0,
        ld_sync: 1'b0,
        fs_meta: 2'b00,
        fs_sync: 2'b00,
        st: OFC_ST_HOLD,
        serial_mode: 1'b0,
        empty_ofs: OFC_OFS_RST,
        full_ofs: OFC_OFS_RST,
        ae_n: 1'b0,
        af_n: 1'b1,
        irq_stat: '0,
        irq_mask: OFC_IRQ_MASK_RST,
        irq: 1'b0,
        rdata: '0,
        pdo: '0,
        rb_full: 1'b0
    };

    ofc_core_state_t s_q;
    ofc_core_state_t s_d;

    // ------------------------------------------------------------------
    // Default offset table
    // ------------------------------------------------------------------
    // Select is {load-select, sel bit1, sel bit0}
    function automatic logic [OFC_OFS_W-1:0] ofc_default_ofs(
        input logic [2:0] sel
    );
        logic [OFC_OFS_W-1:0] v;
        v = OFC_OFS_127;
        case (sel)
            3'h2: v = OFC_OFS_511;
            3'h1: v = OFC_OFS_255;
            3'h0: v = OFC_OFS_127;
            3'h3: v = OFC_OFS_63;
            3'h4: v = OFC_OFS_31;
            3'h6: v = OFC_OFS_15;
            3'h5: v = OFC_OFS_7;
            3'h7: v = OFC_OFS_3;
            default: v = OFC_OFS_127;
        endcase
        return v;
    endfunction : ofc_default_ofs

    // ------------------------------------------------------------------
    // Serial loader
    // ------------------------------------------------------------------
    ofc_ser_if ser ();

    ofc_serial_loader u_loader (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ser(ser.loader)
    );

    // Loader restarts whenever the block is not running
    assign ser.clear = (s_q.st != OFC_ST_RUN);
    assign ser.bit_valid = we_i && (addr_i == OFC_ADDR_SERIAL_IN)
        && s_q.serial_mode && (s_q.st == OFC_ST_RUN);
    assign ser.bit_val = wdata_i[0];

    // ------------------------------------------------------------------
    // Combinational next state
    // ------------------------------------------------------------------
    logic wr_ctrl_ok;
    logic [OFC_CNT_W:0] af_thresh;
    logic ae_n_new;
    logic af_n_new;
    logic [OFC_IRQ_W-1:0] irq_set;
    logic [OFC_IRQ_W-1:0] irq_clr;

    always_comb begin
        s_d = s_q;
        irq_set = '0;
        irq_clr = '0;
        wr_ctrl_ok = 1'b0;
        af_thresh = '0;
        ae_n_new = 1'b0;
        af_n_new = 1'b1;

        // Reset and mode pins pass two flops before anything reads them; FIFO count, read strobe and bus are read directly
        s_d.mr_meta = master_reset_n_i;
        s_d.mr_sync = s_q.mr_meta;
        s_d.ld_meta = offset_load_select_n_i;
        s_d.ld_sync = s_q.ld_meta;
        s_d.fs_meta = {default_offset_sel_bit1_i, default_offset_sel_bit0_i};
        s_d.fs_sync = s_q.fs_meta;

        // Master reset sequencing
        case (s_q.st)
            OFC_ST_HOLD: begin
                // Sample every cycle so the level at release is kept
                s_d.serial_mode = s_q.ld_sync;
                s_d.empty_ofs = ofc_default_ofs({s_q.ld_sync,
                    s_q.fs_sync});
                s_d.full_ofs = ofc_default_ofs({s_q.ld_sync,
                    s_q.fs_sync});
                s_d.rb_full = 1'b0;
                if (s_q.mr_sync) begin
                    s_d.st = OFC_ST_LOAD;
                end
            end
            OFC_ST_LOAD: begin
                // One settle cycle, then programming is open
                irq_set[OFC_IRQ_MR_DONE] = 1'b1;
                s_d.st = s_q.mr_sync ? OFC_ST_RUN : OFC_ST_HOLD;
            end
            OFC_ST_RUN: begin
                wr_ctrl_ok = 1'b1;
                if (!s_q.mr_sync) begin
                    s_d.st = OFC_ST_HOLD;
                end
            end
            default: begin
                s_d.st = OFC_ST_HOLD;
            end
        endcase

        // Parallel programming, open only in parallel mode
        if (we_i && wr_ctrl_ok && !s_q.serial_mode) begin
            if (addr_i == OFC_ADDR_EMPTY_OFS) begin
                s_d.empty_ofs = wdata_i[OFC_OFS_W-1:0];
            end
            if (addr_i == OFC_ADDR_FULL_OFS) begin
                s_d.full_ofs = wdata_i[OFC_OFS_W-1:0];
            end
        end

        // Serial programming completes both offsets at once
        if (ser.word_valid && wr_ctrl_ok && s_q.serial_mode) begin
            s_d.empty_ofs = ser.empty_word;
            s_d.full_ofs = ser.full_word;
            irq_set[OFC_IRQ_SER_DONE] = 1'b1;
        end

        // Mask and W1C status; register state is open in any phase
        if (we_i && addr_i == OFC_ADDR_IRQ_MASK) begin
            s_d.irq_mask = wdata_i[OFC_IRQ_W-1:0];
        end
        if (we_i && addr_i == OFC_ADDR_IRQ_STAT) begin
            irq_clr = wdata_i[OFC_IRQ_W-1:0];
        end

        // Almost-empty: high above n words, low at n or fewer
        ae_n_new = ({1'b0, fifo_count_i} > {2'b00, s_q.empty_ofs});

        // Almost-full: low from depth minus m words upward
        af_thresh = OFC_DEPTH_X - {2'b00, s_q.full_ofs};
        af_n_new = ({1'b0, fifo_count_i} < af_thresh);

        s_d.ae_n = ae_n_new;
        s_d.af_n = af_n_new;

        // Events on the flags going active
        if (s_q.ae_n && !ae_n_new) begin
            irq_set[OFC_IRQ_AE] = 1'b1;
        end
        if (s_q.af_n && !af_n_new) begin
            irq_set[OFC_IRQ_AF] = 1'b1;
        end

        // Set beats clear so no event is lost in a clear cycle
        s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

        // Parallel read-back alternates empty then full offset
        if (offset_read_i && s_q.st == OFC_ST_RUN) begin
            s_d.pdo = '0;
            s_d.pdo[OFC_OFS_W-1:0] = s_q.rb_full ? s_q.full_ofs
                : s_q.empty_ofs;
            s_d.rb_full = !s_q.rb_full;
        end

        // Register read port, data in the cycle after the strobe
        s_d.rdata = '0;
        if (re_i) begin
            case (addr_i)
                OFC_ADDR_CTRL: begin
                    s_d.rdata[OFC_CTRL_SERIAL_BIT] = s_q.serial_mode;
                    s_d.rdata[OFC_CTRL_IN_MR_BIT] = (s_q.st != OFC_ST_RUN);
                end
                OFC_ADDR_EMPTY_OFS: begin
                    s_d.rdata[OFC_OFS_W-1:0] = s_q.empty_ofs;
                end
                OFC_ADDR_FULL_OFS: begin
                    s_d.rdata[OFC_OFS_W-1:0] = s_q.full_ofs;
                end
                OFC_ADDR_FLAGS: begin
                    s_d.rdata[OFC_FLAG_AE_N_BIT] = s_q.ae_n;
                    s_d.rdata[OFC_FLAG_AF_N_BIT] = s_q.af_n;
                end
                OFC_ADDR_IRQ_STAT: begin
                    s_d.rdata[OFC_IRQ_W-1:0] = s_q.irq_stat;
                end
                OFC_ADDR_IRQ_MASK: begin
                    s_d.rdata[OFC_IRQ_W-1:0] = s_q.irq_mask;
                end
                OFC_ADDR_COUNT: begin
                    s_d.rdata[OFC_CNT_W-1:0] = fifo_count_i;
                end
                // Serial input is write only: no serial read-back
                default: begin
                    s_d.rdata = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= OFC_CORE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------------
    assign rdata_o = s_q.rdata;
    assign parallel_data_out_o = s_q.pdo;
    assign almost_empty_flag_n_o = s_q.ae_n;
    assign almost_full_flag_n_o = s_q.af_n;
    assign serial_mode_o = s_q.serial_mode;
    assign irq_o = s_q.irq;

endmodule : ofc_core

// File: tb/ofc_core_properties.sv
// Port-level concurrent checks for the flag offset block
`timescale 1ns/100ps
module ofc_core_checker
    import ofc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic master_reset_n_i,
    input wire logic offset_load_select_n_i,
    input wire logic [OFC_CNT_W-1:0] fifo_count_i,
    input wire logic offset_read_i,
    input wire logic [OFC_ADDR_W-1:0] addr_i,
    input wire logic re_i,
    input wire logic [31:0] rdata_o,
    input wire logic [OFC_DATA_W-1:0] parallel_data_out_o,
    input wire logic almost_empty_flag_n_o,
    input wire logic almost_full_flag_n_o,
    input wire logic serial_mode_o
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Eight cycles cover the two-flop pin sync plus the register
    sequence s_mr_hold;
        (!master_reset_n_i && $stable(offset_load_select_n_i)) [*8];
    endsequence
    sequence s_run;
        master_reset_n_i [*8];
    endsequence

    property p_mode_follow;
        s_mr_hold |-> serial_mode_o == offset_load_select_n_i;
    endproperty
    property p_mode_kept;
        s_run |=> $stable(serial_mode_o);
    endproperty
    // Count 0 never exceeds n, a full FIFO always does
    property p_ae_zero;
        fifo_count_i == '0 |=> !almost_empty_flag_n_o;
    endproperty
    property p_ae_full;
        fifo_count_i == OFC_DEPTH_X[OFC_CNT_W-1:0] |=> almost_empty_flag_n_o;
    endproperty
    // m is at most depth minus one, so threshold lies in 1..1024
    property p_af_full;
        fifo_count_i == OFC_DEPTH_X[OFC_CNT_W-1:0] |=> !almost_full_flag_n_o;
    endproperty
    property p_af_zero;
        fifo_count_i == '0 |=> almost_full_flag_n_o;
    endproperty
    property p_rd_idle;
        !re_i |=> rdata_o == '0;
    endproperty
    property p_rd_unmapped;
        re_i && addr_i > OFC_ADDR_COUNT |=> rdata_o == '0;
    endproperty
    property p_pdo_hold;
        !offset_read_i |=> $stable(parallel_data_out_o);
    endproperty

    a_mode_follow: assert property (p_mode_follow)
        else $error("mode does not follow load select in master reset");
    a_mode_kept: assert property (p_mode_kept)
        else $error("mode changed outside master reset");
    a_ae_zero: assert property (p_ae_zero)
        else $error("almost empty high with no words");
    a_ae_full: assert property (p_ae_full)
        else $error("almost empty low with full count");
    a_af_full: assert property (p_af_full)
        else $error("almost full not low at full count");
    a_af_zero: assert property (p_af_zero)
        else $error("almost full low with no words");
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero after idle cycle");
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read returned nonzero");
    a_pdo_hold: assert property (p_pdo_hold)
        else $error("read-back port changed without request");
endmodule : ofc_core_checker

bind ofc_core ofc_core_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .master_reset_n_i(master_reset_n_i),
    .offset_load_select_n_i(offset_load_select_n_i),
    .fifo_count_i(fifo_count_i), .offset_read_i(offset_read_i),
    .addr_i(addr_i), .re_i(re_i), .rdata_o(rdata_o),
    .parallel_data_out_o(parallel_data_out_o),
    .almost_empty_flag_n_o(almost_empty_flag_n_o),
    .almost_full_flag_n_o(almost_full_flag_n_o),
    .serial_mode_o(serial_mode_o)
);

// File: tb/ofc_host_model.sv
// Host model driving master reset, mode pins and read-back strobe
`timescale 1ns/100ps
module ofc_host_model
    import ofc_pkg::*;
(
    input wire logic clk_i,
    output logic master_reset_n_o,
    output logic offset_load_select_n_o,
    output logic default_offset_sel_bit0_o,
    output logic default_offset_sel_bit1_o,
    output logic offset_read_o
);
    // ------------------------------------------------------------------
    // Pin sequences
    // ------------------------------------------------------------------
    initial begin
        master_reset_n_o = 1'b1;
        offset_load_select_n_o = 1'b0;
        default_offset_sel_bit0_o = 1'b0;
        default_offset_sel_bit1_o = 1'b0;
        offset_read_o = 1'b0;
    end

    // Code is {load select, sel1, sel0}; load select flips afterwards
    // so a mode that is not latched shows up at once
    task master_reset(input logic [2:0] code);
        @(posedge clk_i);
        master_reset_n_o <= 1'b0;
        offset_load_select_n_o <= code[2];
        default_offset_sel_bit1_o <= code[1];
        default_offset_sel_bit0_o <= code[0];
        repeat (10) @(posedge clk_i);
        master_reset_n_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        offset_load_select_n_o <= ~code[2];
        repeat (3) @(posedge clk_i);
    endtask : master_reset

    // One-cycle read-back request
    task read_pulse();
        @(posedge clk_i);
        offset_read_o <= 1'b1;
        @(posedge clk_i);
        offset_read_o <= 1'b0;
    endtask : read_pulse

    // Offsets kept within zero to depth minus one
    function automatic logic [OFC_OFS_W-1:0] legal_ofs(input int v);
        return OFC_OFS_W'(v % OFC_DEPTH);
    endfunction : legal_ofs
endmodule : ofc_host_model

// File: tb/test_ofc_core.sv
// Self-checking bench for the flag offset block
`timescale 1ns/100ps
module test_ofc_core;
    import ofc_pkg::*;
    // ------------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [OFC_CNT_W-1:0] fifo_count_i = '0;
    logic [OFC_ADDR_W-1:0] addr_i = '0;
    logic [31:0] wdata_i = '0;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic mr_n, lsel_n, sel0, sel1, oread, ae_n, af_n, ser, irq;
    logic [31:0] rdata, rv;
    logic [OFC_DATA_W-1:0] pdata;
    int error_cnt = 0;
    int comparisons = 0;
    int n_m, m_m, ser_m;
    int def_tab[8] = '{127, 255, 511, 63, 31, 7, 15, 3};

    initial forever #50 clk_i = ~clk_i;

    ofc_core dut (
        .clk_i(clk_i), .rst_i(rst_i), .master_reset_n_i(mr_n),
        .offset_load_select_n_i(lsel_n),
        .default_offset_sel_bit0_i(sel0), .default_offset_sel_bit1_i(sel1),
        .fifo_count_i(fifo_count_i), .offset_read_i(oread),
        .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
        .rdata_o(rdata), .parallel_data_out_o(pdata),
        .almost_empty_flag_n_o(ae_n), .almost_full_flag_n_o(af_n),
        .serial_mode_o(ser), .irq_o(irq)
    );
    ofc_host_model host (
        .clk_i(clk_i), .master_reset_n_o(mr_n),
        .offset_load_select_n_o(lsel_n),
        .default_offset_sel_bit0_o(sel0), .default_offset_sel_bit1_o(sel1),
        .offset_read_o(oread)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task chk_w(input logic [OFC_DATA_W-1:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %0h exp %0h", $time, what,
                got, exp);
        end
    endtask : chk_w
    task chk_b(input logic got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %b", $time, what, got);
        end
    endtask : chk_b
    task wr(input logic [OFC_ADDR_W-1:0] a, input int d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task rd(input logic [OFC_ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task rd_ofs();
        rd(OFC_ADDR_EMPTY_OFS, rv);
        chk_w(36'(rv), 36'(n_m), "empty offset");
        rd(OFC_ADDR_FULL_OFS, rv);
        chk_w(36'(rv), 36'(m_m), "full offset");
    endtask : rd_ofs
    // Read-back alternates empty then full offset
    task readback();
        host.read_pulse();
        #1 chk_w(pdata, 36'(n_m), "readback n");
        host.read_pulse();
        #1 chk_w(pdata, 36'(m_m), "readback m");
    endtask : readback
    // Flags settle one register stage after the count
    task flags(input int cnt);
        @(posedge clk_i);
        fifo_count_i <= OFC_CNT_W'(cnt);
        repeat (2) @(posedge clk_i);
        #1 chk_b(ae_n, cnt > n_m, "almost empty");
        chk_b(af_n, cnt < OFC_DEPTH - m_m, "almost full");
    endtask : flags
    task conclude();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        void'($urandom(32'h7160));
        // Every default code, mode latch and read-back order
        for (int c = 0; c < 8; c++) begin
            host.master_reset(3'(c));
            ser_m = c / 4;
            n_m = def_tab[c];
            m_m = n_m;
            rd_ofs();
            rd(OFC_ADDR_CTRL, rv);
            chk_b(rv[OFC_CTRL_SERIAL_BIT], ser_m[0], "ctrl");
            chk_b(ser, ser_m[0], "mode pin");
            readback();
        end
        chk_b(irq, 1'b0, "masked irq");
        // Serial mode: parallel writes refused, 20-bit serial load
        wr(OFC_ADDR_EMPTY_OFS, 5);
        rd_ofs();
        wr(OFC_ADDR_IRQ_MASK, 8);
        n_m = host.legal_ofs($urandom);
        m_m = host.legal_ofs($urandom);
        for (int i = 0; i < 20; i++) begin
            wr(OFC_ADDR_SERIAL_IN,
                i < 10 ? (n_m >> i) & 1 : (m_m >> (i - 10)) & 1);
        end
        repeat (4) @(posedge clk_i);
        #1 chk_b(irq, 1'b1, "serial done irq");
        rd_ofs();
        readback();
        wr(OFC_ADDR_IRQ_STAT, 8);
        repeat (2) @(posedge clk_i);
        #1 chk_b(irq, 1'b0, "irq cleared");
        rd(8'h40, rv);
        chk_w(36'(rv), '0, "unmapped");
        // Parallel mode: boundary and random offsets, flags both ways
        host.master_reset(3'b000);
        for (int k = 0; k < 3; k++) begin
            n_m = k == 0 ? 0 : k == 1 ? 1023 : host.legal_ofs($urandom);
            m_m = k == 0 ? 1023 : k == 1 ? 0 : host.legal_ofs($urandom);
            wr(OFC_ADDR_EMPTY_OFS, n_m);
            wr(OFC_ADDR_FULL_OFS, m_m);
            rd_ofs();
            readback();
            flags(n_m + 1);
            flags(n_m);
            flags(OFC_DEPTH - m_m - 1);
            flags(OFC_DEPTH - m_m);
        end
        conclude();
    end

    // Cuts a hang short
    initial begin
        repeat (60000) @(posedge clk_i);
        error_cnt++;
        conclude();
    end
endmodule : test_ofc_core
